// [design/mps_seq_inputs.sv]
// microprogram sequencer and its steered inputs
`default_nettype none
module mps_seq_inputs #(
  parameter logic [23:0] COND_MAP = mps_pkg::MPS_COND_MAP
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [mps_pkg::MPS_UWORD_W-1:0] i_uword,
  input wire mps_pkg::mps_cond_t i_board_cond,
  input wire logic i_carry_or_shift_out,
  input wire logic i_busy_start,
  input wire logic i_phase_one_clock_n,
  input wire logic i_master_reset_n,
  input wire mps_pkg::mps_gsel_t i_group_select,
  input wire logic [2:0] i_array_data,
  input wire logic [2:0] i_chan_cmd_addr,
  output logic [mps_pkg::MPS_UADDR_W-1:0] o_uaddr,
  output logic [3:0] o_primary_ibus,
  output logic [3:0] o_secondary_ibus,
  output logic o_branch_ctrl_low,
  output logic o_sequencer_load,
  output logic o_flag
);
  import mps_pkg::*;

  // enables of the sequencer are never pulled low
  localparam logic SEQ_ENABLE = 1'h1;
  localparam logic ROW_ADDRESS_ENABLE = 1'h1;

  mps_state_t st_ff;
  mps_state_t nxt_st;
  logic [5:0] branch_ctrl_hi;
  logic [6:0] branch_ctrl;
  logic [2:0] cond_select;
  logic [7:0] cond_src;
  logic flag_ctrl_0;
  logic flag_ctrl_1;
  logic flag_ctrl_2;
  logic flag_ctrl_3;
  logic flag_logic_in;
  logic sequencer_load;
  logic step;
  logic [3:0] group_a;
  logic [3:0] group_b;
  logic [3:0] primary_ibus;
  logic [3:0] secondary_ibus;

  // row part of an address
  function automatic logic [4:0] row_of(input logic [8:0] a);
    row_of = a[8:4];
  endfunction

  // column part of an address
  function automatic logic [3:0] col_of(input logic [8:0] a);
    col_of = a[3:0];
  endfunction

  // next address from branch controls and the two buses
  function automatic logic [8:0] next_addr(
    input logic [6:0] ac,
    input logic [8:0] a,
    input logic [3:0] px,
    input logic [3:0] sx,
    input logic fl
  );
    logic [4:0] r;
    r = row_of(a);
    case (ac[6:4])
      MPS_BR_ROW: next_addr = {r, ac[3:0]};
      MPS_BR_ZERO: next_addr = {5'h00, ac[3:0]};
      MPS_BR_JROW: next_addr = {1'h0, ac[3:0], col_of(a)};
      MPS_BR_PRI: next_addr = {r, px};
      MPS_BR_SEC: next_addr = {r, sx};
      MPS_BR_FLAG: next_addr = {r, ac[3:1], fl};
      MPS_BR_COND: next_addr = {r, ac[3:1], ac[0]};
      MPS_BR_BOTH: next_addr = {r, ac[3:1], fl & ac[0]};
      default: next_addr = a;
    endcase
  endfunction

  assign branch_ctrl_hi = i_uword[MPS_AC_HI_LSB +: MPS_AC_HI_W];
  assign cond_select = i_uword[MPS_CSEL_LSB +: MPS_SEL_W];

  always_comb begin
    cond_src = 8'h00;
    cond_src[MPS_SRC_ZERO] = st_ff.cond_s2.all_zero_cond;
    cond_src[MPS_SRC_INDEX] = st_ff.cond_s2.index_cond;
    cond_src[MPS_SRC_XFER] = st_ff.cond_s2.transfer_request_cond;
    cond_src[MPS_SRC_TMO] = st_ff.cond_s2.timeout_cond;
    cond_src[MPS_SRC_FLAG] = st_ff.cond_s2.flag_cond;
    cond_src[MPS_SRC_CARRY] = i_carry_or_shift_out;
    cond_src[MPS_SRC_BUSY] = i_busy_start;
    cond_src[MPS_SRC_BIT26] = i_uword[MPS_AC0_BIT];
  end

  // condition multiplexer into the lowest branch control
  mps_cond_mux #(
    .SEL_MAP(COND_MAP)
  ) u_cond_mux (
    .i_sources(cond_src),
    .i_select(cond_select),
    .o_branch_ctrl_low(o_branch_ctrl_low)
  );

  assign branch_ctrl = {branch_ctrl_hi, o_branch_ctrl_low};

  assign flag_ctrl_0 = i_uword[MPS_FC_IN_BIT];
  assign flag_ctrl_1 = i_uword[MPS_FC_IN_BIT];
  assign flag_ctrl_2 = i_uword[MPS_FC_OUT_BIT];
  assign flag_ctrl_3 = i_uword[MPS_FC_OUT_BIT];

  assign flag_logic_in = i_carry_or_shift_out;

  assign sequencer_load = ~st_ff.mr_s2;

  assign step = SEQ_ENABLE & ROW_ADDRESS_ENABLE & st_ff.phase_prev
    & ~st_ff.phase_s2;

  assign group_a = {~i_array_data, 1'h1};
  assign group_b = {~i_chan_cmd_addr, 1'h0};

  always_comb begin
    primary_ibus = MPS_PX_IDLE;
    if (!i_group_select.group_select_0) begin
      primary_ibus = ~group_b;
    end else if (!i_group_select.group_select_1) begin
      primary_ibus = ~group_a;
    end
  end

  // secondary bus forced or complemented
  always_comb begin
    if (sequencer_load) begin
      secondary_ibus = MPS_SX_FORCED;
    end else begin
      secondary_ibus = ~col_of(st_ff.uaddr);
    end
  end

  // next state of synchronisers, flag and address
  always_comb begin
    nxt_st = st_ff;
    nxt_st.phase_s1 = i_phase_one_clock_n;
    nxt_st.phase_s2 = st_ff.phase_s1;
    nxt_st.phase_prev = st_ff.phase_s2;
    nxt_st.mr_s1 = i_master_reset_n;
    nxt_st.mr_s2 = st_ff.mr_s1;
    nxt_st.cond_s1 = i_board_cond;
    nxt_st.cond_s2 = st_ff.cond_s1;
    if (sequencer_load) begin
      nxt_st.uaddr = {5'h00, ~secondary_ibus};
      nxt_st.flag = 1'h0;
    end else if (step) begin
      nxt_st.uaddr = next_addr(branch_ctrl, st_ff.uaddr, primary_ibus,
        secondary_ibus, flag_ctrl_2 ? st_ff.flag : o_branch_ctrl_low);
      if (flag_ctrl_0 & flag_ctrl_1) begin
        nxt_st.flag = flag_logic_in;
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_ff.uaddr <= MPS_RST_ADDR;
      st_ff.flag <= 1'h0;
      st_ff.phase_s1 <= MPS_PHASE_IDLE;
      st_ff.phase_s2 <= MPS_PHASE_IDLE;
      st_ff.phase_prev <= MPS_PHASE_IDLE;
      st_ff.mr_s1 <= MPS_MR_RST;
      st_ff.mr_s2 <= MPS_MR_RST;
      st_ff.cond_s1 <= '0;
      st_ff.cond_s2 <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_uaddr = st_ff.uaddr;
  assign o_primary_ibus = primary_ibus;
  assign o_secondary_ibus = secondary_ibus;
  assign o_sequencer_load = sequencer_load;
  assign o_flag = st_ff.flag;

  // checks of the steering and the sequencing

  sequence reset_pin_low;
    !i_master_reset_n ##1 !i_master_reset_n;
  endsequence

  sequence phase_fall_seen;
    st_ff.phase_prev && !st_ff.phase_s2;
  endsequence

  upper_ctrl_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    branch_ctrl[6:1] == i_uword[31:26])
    else $error("upper branch controls not from word bits");

  reset_load_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    reset_pin_low |=> o_sequencer_load ##1 (o_uaddr == MPS_RST_ADDR))
    else $error("reset pin did not load the address");

  sx_forced_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_sequencer_load |-> o_secondary_ibus == 4'hf)
    else $error("secondary bus not forced high in reset");

  sx_follow_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !o_sequencer_load |-> o_secondary_ibus == ~o_uaddr[3:0])
    else $error("secondary bus not complement of address");

  px_group_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_group_select == 2'b01) |-> o_primary_ibus == {i_array_data, 1'h0})
    else $error("primary bus wrong for operation group");

  px_cmd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_group_select.group_select_0
      |-> o_primary_ibus == {i_chan_cmd_addr, 1'h1})
    else $error("primary bus wrong for command group");

  step_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (phase_fall_seen and !o_sequencer_load
      and i_uword[31:29] == MPS_BR_ZERO)
      |=> o_uaddr == {5'h00, $past(i_uword[28:26]),
        $past(o_branch_ctrl_low)})
    else $error("zero-row jump not taken on phase edge");

  addr_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!step && !o_sequencer_load) |=> $stable(o_uaddr))
    else $error("address moved without a phase edge");

  flag_take_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (step && !o_sequencer_load && i_uword[16])
      |=> o_flag == $past(i_carry_or_shift_out))
    else $error("flag did not capture carry out");

  cond_bit26_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (COND_MAP == MPS_COND_MAP && cond_select == 3'h7)
      |-> o_branch_ctrl_low == i_uword[25])
    else $error("condition select 7 not bit 26");

  pin_step_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ($fell(i_phase_one_clock_n) && i_master_reset_n) ##1 i_master_reset_n
      |=> phase_fall_seen)
    else $error("phase pin edge not seen after two stages");
endmodule
`default_nettype wire

// [design/mps_pkg.sv]
// constants and carrier types of the microprogram next-address logic
`default_nettype none
package mps_pkg;
  // word and address geometry
  localparam int MPS_UWORD_W = 32;
  localparam int MPS_STORE_DEPTH = 512;
  localparam int MPS_UADDR_W = 9;
  localparam int MPS_ROW_W = 5;
  localparam int MPS_COL_W = 4;
  localparam int MPS_IBUS_W = 4;
  localparam int MPS_NCOND = 8;
  localparam int MPS_SEL_W = 3;
  // field positions inside the word (word bit n sits at index n-1)
  localparam int MPS_AC_HI_LSB = 26;
  localparam int MPS_AC_HI_W = 6;
  localparam int MPS_AC0_BIT = 25;
  localparam int MPS_CSEL_LSB = 13;
  localparam int MPS_FC_IN_BIT = 16;
  localparam int MPS_FC_OUT_BIT = 17;
  // reset values
  localparam logic [8:0] MPS_RST_ADDR = 9'h000;
  localparam logic [3:0] MPS_SX_FORCED = 4'hf;
  localparam logic [3:0] MPS_PX_IDLE = 4'hf;
  localparam logic MPS_PHASE_IDLE = 1'h1;
  localparam logic MPS_MR_RST = 1'h0;
  // condition source indexes per select code, three bits each
  localparam logic [23:0] MPS_COND_MAP = 24'hfac688;
  // condition source positions
  localparam logic [2:0] MPS_SRC_ZERO = 3'h0;
  localparam logic [2:0] MPS_SRC_INDEX = 3'h1;
  localparam logic [2:0] MPS_SRC_XFER = 3'h2;
  localparam logic [2:0] MPS_SRC_TMO = 3'h3;
  localparam logic [2:0] MPS_SRC_FLAG = 3'h4;
  localparam logic [2:0] MPS_SRC_CARRY = 3'h5;
  localparam logic [2:0] MPS_SRC_BUSY = 3'h6;
  localparam logic [2:0] MPS_SRC_BIT26 = 3'h7;
  // branch modes, taken from the top three address-control bits
  localparam logic [2:0] MPS_BR_ROW = 3'h0;
  localparam logic [2:0] MPS_BR_ZERO = 3'h1;
  localparam logic [2:0] MPS_BR_JROW = 3'h2;
  localparam logic [2:0] MPS_BR_PRI = 3'h3;
  localparam logic [2:0] MPS_BR_SEC = 3'h4;
  localparam logic [2:0] MPS_BR_FLAG = 3'h5;
  localparam logic [2:0] MPS_BR_COND = 3'h6;
  localparam logic [2:0] MPS_BR_BOTH = 3'h7;

  // interface-board condition lines
  typedef struct packed {
    logic all_zero_cond;
    logic index_cond;
    logic transfer_request_cond;
    logic timeout_cond;
    logic flag_cond;
  } mps_cond_t;

  // group multiplexer select pair
  typedef struct packed {
    logic group_select_1;
    logic group_select_0;
  } mps_gsel_t;

  // whole state of the sequencer block
  typedef struct packed {
    logic [8:0] uaddr;
    logic flag;
    logic phase_s1;
    logic phase_s2;
    logic phase_prev;
    logic mr_s1;
    logic mr_s2;
    mps_cond_t cond_s1;
    mps_cond_t cond_s2;
  } mps_state_t;
endpackage
`default_nettype wire

// [design/mps_cond_mux.sv]
// eight-to-one condition multiplexer with a settable select mapping
`default_nettype none
module mps_cond_mux #(
  parameter logic [23:0] SEL_MAP = mps_pkg::MPS_COND_MAP
) (
  input wire logic [7:0] i_sources,
  input wire logic [2:0] i_select,
  output logic o_branch_ctrl_low
);
  import mps_pkg::*;

  logic [7:0] routed;

  // route each select code to its mapped source
  // mapping is parameter
  genvar g;
  generate
    for (g = 0; g < MPS_NCOND; g++) begin : g_route
      assign routed[g] = i_sources[SEL_MAP[g*3 +: 3]];
    end
  endgenerate

  assign o_branch_ctrl_low = routed[i_select];
endmodule
`default_nettype wire

// [testbench/mps_ustore.sv]
// microprogram store model answering the sequencer address
`default_nettype none
module mps_ustore (
  input wire logic [8:0] i_uaddr,
  output logic [31:0] o_uword
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [512];
  assign o_uword = mem[i_uaddr];
  // blank store until the bench loads words
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [testbench/mps_seq_inputs_tb.sv]
// self-checking bench for the sequencer input steering
`default_nettype none
module mps_seq_inputs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mps_pkg::*;
  logic i_core_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [31:0] i_uword;
  mps_cond_t i_board_cond = 5'h00;
  logic i_carry_or_shift_out = 1'h0;
  logic i_busy_start = 1'h0;
  logic i_phase_one_clock_n = 1'h1;
  logic i_master_reset_n = 1'h1;
  mps_gsel_t i_group_select = 2'h0;
  logic [2:0] i_array_data = 3'h0;
  logic [2:0] i_chan_cmd_addr = 3'h0;
  logic [8:0] o_uaddr;
  logic [3:0] o_primary_ibus;
  logic [3:0] o_secondary_ibus;
  logic o_branch_ctrl_low;
  logic o_sequencer_load;
  logic o_flag;
  int error_cnt = 0;
  int n_compared = 0;

  // design and its store
  mps_seq_inputs mps_seq_inputs_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_uword(i_uword),
    .i_board_cond(i_board_cond),
    .i_carry_or_shift_out(i_carry_or_shift_out),
    .i_busy_start(i_busy_start),
    .i_phase_one_clock_n(i_phase_one_clock_n),
    .i_master_reset_n(i_master_reset_n),
    .i_group_select(i_group_select), .i_array_data(i_array_data),
    .i_chan_cmd_addr(i_chan_cmd_addr), .o_uaddr(o_uaddr),
    .o_primary_ibus(o_primary_ibus), .o_secondary_ibus(o_secondary_ibus),
    .o_branch_ctrl_low(o_branch_ctrl_low),
    .o_sequencer_load(o_sequencer_load), .o_flag(o_flag)
  );
  mps_ustore mps_ustore_inst (.i_uaddr(o_uaddr), .o_uword(i_uword));

  // 50 ns core clock
  always #25 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // sources in mux order, select code into the current word
  task automatic set_src(input logic [7:0] s, input logic [2:0] sel);
    @(posedge i_core_clk);
    i_board_cond <= {s[0], s[1], s[2], s[3], s[4]};
    i_carry_or_shift_out <= s[5];
    i_busy_start <= s[6];
    mps_ustore_inst.mem[o_uaddr] <= {6'h00, s[7], 9'h000, sel, 13'h0000};
    tick(3);
  endtask

  // one phase-one low pulse, then settle
  task automatic step;
    @(posedge i_core_clk);
    i_phase_one_clock_n <= 1'h0;
    tick(3);
    @(posedge i_core_clk);
    i_phase_one_clock_n <= 1'h1;
    tick(3);
  endtask

  task automatic test_cond;
    logic [2:0] k;
    for (int s = 0; s < 8; s++) begin
      k = MPS_COND_MAP[3*s +: 3];
      set_src(8'h01 << k, 3'(s));
      chk(9'(o_branch_ctrl_low), 9'h001);
      set_src(~(8'h01 << k), 3'(s));
      chk(9'(o_branch_ctrl_low), 9'h000);
    end
    $display("test_cond done");
  endtask

  task automatic test_steer;
    for (int v = 0; v < 8; v++) begin
      @(posedge i_core_clk);
      i_array_data <= 3'(v);
      i_chan_cmd_addr <= 3'(7 - v);
      i_group_select <= 2'h1;
      tick(1);
      chk(9'({3'(v), 1'h0}), 9'(o_primary_ibus));
      @(posedge i_core_clk);
      i_group_select <= 2'h2;
      tick(1);
      chk(9'({3'(7 - v), 1'h1}), 9'(o_primary_ibus));
    end
    @(posedge i_core_clk);
    i_group_select <= 2'h3;
    tick(1);
    chk(9'(o_primary_ibus), 9'h00f);
    $display("test_steer done");
  endtask

  task automatic test_step;
    set_src(8'hff, 3'h0);
    @(posedge i_core_clk);
    i_group_select <= 2'h0;
    i_chan_cmd_addr <= 3'h2;
    // mode 1, ac3..ac1 = 101, bit 17 set
    mps_ustore_inst.mem[9'h000] <= 32'h3401_0000;
    tick(5);
    chk(o_uaddr, 9'h000);
    step();
    chk(o_uaddr, 9'h00b);
    chk(9'(o_secondary_ibus), 9'h004);
    chk(9'(o_flag), 9'h001);
    // mode 3 takes the primary bus
    mps_ustore_inst.mem[9'h00b] <= 32'h6000_0000;
    step();
    chk(o_uaddr, 9'h005);
    chk(9'(o_secondary_ibus), 9'h00a);
    @(posedge i_core_clk);
    i_master_reset_n <= 1'h0;
    tick(3);
    chk(9'(o_sequencer_load), 9'h001);
    chk(o_uaddr, 9'h000);
    chk(9'(o_secondary_ibus), 9'h00f);
    chk(9'(o_flag), 9'h000);
    @(posedge i_core_clk);
    i_master_reset_n <= 1'h1;
    tick(4);
    chk(9'(o_sequencer_load), 9'h000);
    $display("test_step done");
  endtask

  // main sequence
  initial begin
    tick(20);
    chk(o_uaddr, 9'h000);
    chk(9'(o_sequencer_load), 9'h001);
    chk(9'(o_secondary_ibus), 9'h00f);
    @(posedge i_core_clk);
    i_reset <= 1'h0;
    tick(4);
    chk(9'(o_sequencer_load), 9'h000);
    test_cond();
    test_steer();
    test_step();
    test_done();
  end

  // watchdog cuts a hang short
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
